// >>> logic/fdh_pkg.sv
// constants, register map and carrier types of the host status registers
// Notes on behaviour
// RULE1 - legacy mode: gate bit 0 blocks acknowledge and terminal count, floats requests.
// RULE2 - alternate mode: gate bit reserved, DMA signals always enabled, reset too.
// RULE3 - two-drive setup: motor 0 from bit 4, motor 1 from bit 5.
// RULE4 - bit 6 drives motor 2 in four-drive setup or 0/2 exchange.
// RULE5 - four-drive setup: bits 4..7 enable motors, gated by drive select.
// RULE6 - drive select decodes to one select output; 10/11 need drives 2/3.
// RULE7 - configuration bit picks compatible or enhanced tape register; compatible floats 7..2 (here they read 0).
// RULE8 - tape select: 00 none, 01..11 drives 1..3, never drive 0.
// RULE9 - enhanced only: exchange 01 swaps drives 0/1, 10 swaps 0/2, 11 reserved.
// RULE10 - no exchange in four-drive setup; drive 3 never swapped with 2.
// RULE11 - id bits from id config: bits 1,0 for select 00, 3,2 for 01.
// RULE12 - enhanced: bits 7,6 mirror the two media sense inputs.
// RULE13 - reset: enhanced id bits read 1, low bits 0; select bits cleared.
// RULE14 - status reads zero after any reset or wake until initialised.
// RULE15 - ready status is request bit only, within 2.5 ms of reset.
// RULE16 - host reads status before each non-DMA data byte, no delay needed.
// RULE17 - drive busy set after seek/home command, cleared on its sense result.
// RULE18 - progress bit set on first command byte, cleared at command end.
// RULE19 - non-DMA execution bit shown during interrupt or polled transfers.
// RULE20 - direction bit: 0 host writes next byte, 1 host reads it.
// RULE21 - request bit cleared after each data byte, set when ready again.
// RULE22 - status register is read only; writes change nothing.
package fdh_pkg;
   localparam int        WB_AW          = 4;
   localparam logic [3:0] OFS_DOC       = 4'h0;
   localparam logic [3:0] OFS_TMDT      = 4'h4;
   localparam logic [3:0] OFS_MCS       = 4'h8;
   localparam logic [3:0] OFS_CFG       = 4'hC;
   localparam logic [7:0] DOC_RESET     = 8'h00;
   localparam logic [15:0] CFG_RESET    = 16'h0000;
   localparam logic [7:0] MCS_READY     = 8'h80;
   localparam int        DOC_DS_LO      = 0;
   localparam int        DOC_RUN        = 2;
   localparam int        DOC_DMA        = 3;
   localparam int        DOC_MOT_LO     = 4;
   localparam int        CFG_FOUR       = 0;
   localparam int        CFG_ENH        = 1;
   localparam int        CFG_ALT        = 2;
   localparam int        CFG_ID_LO      = 8;
   localparam int        TD_EXCH_LO     = 2;
   localparam int        TD_ID_LO       = 4;
   localparam int        TD_MED_LO      = 6;
   localparam int        MS_DIO         = 6;
   localparam int        MS_NDMA        = 5;
   localparam int        MS_CIP         = 4;
   localparam int        MS_RQM         = 7;
   localparam logic [1:0] XCH_NONE      = 2'h0;
   localparam logic [1:0] XCH_01        = 2'h1;
   localparam logic [1:0] XCH_02        = 2'h2;
   localparam logic [1:0] ID_RESET      = 2'h3;
   localparam int        CLK_PERIOD_NS  = 10;
   localparam int        READY_TIME_NS  = 2500000;
   // longest time: round down
   localparam int        READY_CYCLES   = READY_TIME_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic       cmd_first;
      logic       cmd_last;
      logic       no_result;
      logic       seek_done;
      logic [1:0] seek_drv;
      logic       sense_rd;
      logic [1:0] sense_drv;
      logic       result_last;
      logic       data_xfer;
      logic       ready;
      logic       exec_nondma;
      logic       dir_read;
   } fdh_evt_t;

   typedef struct packed {
      logic media_sense_high;
      logic media_sense_low;
      logic tc;
      logic dack_n;
   } fdh_pins_t;
endpackage : fdh_pkg

// >>> logic/fdh_host_regs.sv
// output control, tape/media and main status registers on wishbone
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module fdh_host_regs
#(
   parameter int INIT_CYCLES = fdh_pkg::READY_CYCLES
)
(
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [fdh_pkg::WB_AW-1:0] wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire fdh_pkg::fdh_evt_t  evt_i,
   input  wire logic               pwr_down,
   input  wire fdh_pkg::fdh_pins_t pins_i,
   input  wire logic               drq_req,
   input  wire logic               irq_req,
   output logic      [3:0]         drive_sel,
   output logic      [3:0]         motor_on,
   output logic      [3:0]         tape_drive,
   output logic                    ctrl_run,
   output logic                    dack_gated_n,
   output logic                    tc_gated,
   output logic                    drq_o,
   output logic                    drq_oe_n,
   output logic                    irq_o,
   output logic                    irq_oe_n
);
   import fdh_pkg::*;

   logic [7:0]  doc_r;
   logic [7:0]  tsel_r;
   logic        id_rst_r;
   logic [15:0] cfg_r;
   logic [3:0]  busy_r;
   logic        cip_r;
   logic        rqm_r;
   logic        init_done_r;
   logic [31:0] init_cnt_r;
   logic [31:0] rdat_nxt;
   logic        wr_go;
   logic        rd_go;
   logic        hold;
   logic        four;
   logic        enh;
   logic [1:0]  xch;
   logic [1:0]  ds;
   logic [3:0]  ld_sel;
   logic [3:0]  ld_mot;
   logic        dma_en;
   logic [3:0]  s1_r;
   logic [3:0]  s2_r;
   logic [3:0]  s3_r;
   logic [3:0]  pin_f_r;
   logic [7:0]  tmdt_rd;
   logic [7:0]  mcs_rd;

   // swap physical pin assignment for a logical exchange
   function automatic logic [3:0] fdh_swap(input logic [3:0] v,
                                           input logic [1:0] x);
      logic [3:0] r;
      r = v;
      if (x == XCH_01)
      begin
         r[0] = v[1];
         r[1] = v[0];
      end
      else if (x == XCH_02)
      begin
         r[0] = v[2];
         r[2] = v[0];
      end
      return r;
   endfunction : fdh_swap

   // one-hot decode of a two-bit drive number
   function automatic logic [3:0] fdh_dec(input logic [1:0] n);
      return 4'h1 << n;
   endfunction : fdh_dec

   // pin synchronisers, value accepted when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
            begin
               s1_r[gi]    <= 1'b0;
               s2_r[gi]    <= 1'b0;
               s3_r[gi]    <= 1'b0;
               pin_f_r[gi] <= 1'b0;
            end
            else
            begin
               s1_r[gi] <= pins_i[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi])
                  pin_f_r[gi] <= s3_r[gi];
            end
         end
      end
   endgenerate

   assign four   = cfg_r[CFG_FOUR];
   assign enh    = cfg_r[CFG_ENH];                               // RULE7
   assign ds     = doc_r[DOC_DS_LO +: 2];
   // exchange only in enhanced mode, never with four drives, 11 ignored
   assign xch    = (enh && !four && tsel_r[TD_EXCH_LO +: 2] != 2'h3)
                   ? tsel_r[TD_EXCH_LO +: 2] : XCH_NONE;         // RULE9 RULE10
   assign dma_en = cfg_r[CFG_ALT] ? 1'b1 : doc_r[DOC_DMA];       // RULE1 RULE2
   assign hold   = !init_done_r || !doc_r[DOC_RUN] || pwr_down;

   // logical drive select, drives 2/3 only when available
   always_comb
   begin
      ld_sel = fdh_dec(ds);                                      // RULE6
      if (ds == 2'h2 && !(four || xch == XCH_02))
         ld_sel = 4'h0;
      if (ds == 2'h3 && !four)
         ld_sel = 4'h0;
   end

   // logical motor enables
   always_comb
   begin
      if (four)
         ld_mot = doc_r[DOC_MOT_LO +: 4] & fdh_dec(ds);          // RULE5 RULE4
      else
         ld_mot = {1'b0, doc_r[DOC_MOT_LO + 2] && xch == XCH_02, // RULE4
                   doc_r[DOC_MOT_LO +: 2]};                      // RULE3
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         drive_sel  <= 4'h0;
         motor_on   <= 4'h0;
         tape_drive <= 4'h0;
         ctrl_run   <= 1'b0;
      end
      else
      begin
         drive_sel  <= fdh_swap(ld_sel, xch);                    // RULE6
         motor_on   <= fdh_swap(ld_mot, xch);                    // RULE3 RULE5
         tape_drive <= fdh_dec(tsel_r[1:0]) & 4'hE;              // RULE8
         ctrl_run   <= doc_r[DOC_RUN];
      end
   end

   // dma side signals, gating is untouched by the soft reset bit
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         dack_gated_n <= 1'b1;
         tc_gated     <= 1'b0;
         drq_o        <= 1'b0;
         drq_oe_n     <= 1'b1;
         irq_o        <= 1'b0;
         irq_oe_n     <= 1'b1;
      end
      else
      begin
         dack_gated_n <= dma_en ? pin_f_r[0] : 1'b1;             // RULE1
         tc_gated     <= dma_en & pin_f_r[1];                    // RULE1
         drq_o        <= drq_req;
         drq_oe_n     <= !dma_en;                                // RULE1 RULE2
         irq_o        <= irq_req;
         irq_oe_n     <= !dma_en;                                // RULE1 RULE2
      end
   end

   // wishbone classic: one wait state, ack for one cycle
   assign wr_go = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         doc_r <= DOC_RESET;
         cfg_r <= CFG_RESET;
      end
      else if (wr_go)
      begin
         if (wb_adr_i == OFS_DOC && wb_sel_i[0])
            doc_r <= wb_dat_i[7:0];
         if (wb_adr_i == OFS_CFG && wb_sel_i[0])
            cfg_r[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == OFS_CFG && wb_sel_i[1])
            cfg_r[15:8] <= wb_dat_i[15:8];
      end
   end

   // tape register: select always writable, exchange in enhanced mode
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tsel_r   <= 8'h00;                                      // RULE13
         id_rst_r <= 1'b1;                                       // RULE13
      end
      else if (wr_go && wb_sel_i[0] &&
               (wb_adr_i == OFS_TMDT || wb_adr_i == OFS_DOC))
      begin
         id_rst_r <= 1'b0;
         if (wb_adr_i == OFS_TMDT)
         begin
            tsel_r[1:0] <= wb_dat_i[1:0];                        // RULE8
            if (enh)
               tsel_r[TD_EXCH_LO +: 2] <= wb_dat_i[TD_EXCH_LO +: 2];
         end
      end
   end

   // read view of the tape register
   always_comb
   begin
      tmdt_rd = 8'h00;
      tmdt_rd[1:0] = tsel_r[1:0];
      if (enh)
      begin
         tmdt_rd[TD_EXCH_LO +: 2] = tsel_r[TD_EXCH_LO +: 2];
         if (id_rst_r)
            tmdt_rd[TD_ID_LO +: 2] = ID_RESET;                   // RULE13
         else if (ds == 2'h0)
            tmdt_rd[TD_ID_LO +: 2] = cfg_r[CFG_ID_LO +: 2];      // RULE11
         else if (ds == 2'h1)
            tmdt_rd[TD_ID_LO +: 2] = cfg_r[CFG_ID_LO + 2 +: 2];  // RULE11
         tmdt_rd[TD_MED_LO +: 2] = pin_f_r[3:2];                 // RULE12
      end
   end

   // initialisation wait after any reset or wake
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         init_cnt_r  <= 32'h0;
         init_done_r <= 1'b0;
      end
      else if (!doc_r[DOC_RUN] || pwr_down)
      begin
         init_cnt_r  <= 32'h0;
         init_done_r <= 1'b0;                                    // RULE14
      end
      else if (!init_done_r)
      begin
         init_cnt_r  <= init_cnt_r + 32'h1;
         init_done_r <= (init_cnt_r >= 32'(INIT_CYCLES - 3));    // RULE15
      end
   end

   // drive busy flags, a set wins over a sense clear in the same cycle
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_busy
         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
               busy_r[gi] <= 1'b0;
            else if (hold)
               busy_r[gi] <= 1'b0;                               // RULE14
            else if (evt_i.seek_done && evt_i.seek_drv == 2'(gi))
               busy_r[gi] <= 1'b1;                               // RULE17
            else if (evt_i.sense_rd && evt_i.sense_drv == 2'(gi))
               busy_r[gi] <= 1'b0;                               // RULE17
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         cip_r <= 1'b0;
      else if (hold)
         cip_r <= 1'b0;
      else if (evt_i.cmd_first)
         cip_r <= 1'b1;                                          // RULE18
      else if (evt_i.result_last || (evt_i.cmd_last && evt_i.no_result))
         cip_r <= 1'b0;                                          // RULE18
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rqm_r <= 1'b0;
      else if (hold || evt_i.data_xfer)
         rqm_r <= 1'b0;                                          // RULE21
      else
         rqm_r <= evt_i.ready;                                   // RULE21 RULE15
   end

   // status view, zero while held; no write path exists
   always_comb
   begin
      mcs_rd          = {4'h0, busy_r};                          // RULE22
      mcs_rd[MS_CIP]  = cip_r;
      mcs_rd[MS_NDMA] = evt_i.exec_nondma;                       // RULE19
      mcs_rd[MS_DIO]  = evt_i.dir_read;                          // RULE20
      mcs_rd[MS_RQM]  = rqm_r;
      if (hold)
         mcs_rd = 8'h00;                                         // RULE14
   end

   always_comb
   begin
      unique case (wb_adr_i)
         OFS_DOC:  rdat_nxt = {24'h0, doc_r};
         OFS_TMDT: rdat_nxt = {24'h0, tmdt_rd};                  // RULE7
         OFS_MCS:  rdat_nxt = {24'h0, mcs_rd};
         OFS_CFG:  rdat_nxt = {16'h0, cfg_r};
         default:  rdat_nxt = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= rd_go;
         wb_dat_o <= (rd_go && !wb_we_i) ? rdat_nxt : 32'h0;
      end
   end

   a_busy_set: assert property ( // RULE17
      @(posedge sys_clk) disable iff (rst)
      (!hold && evt_i.seek_done) |=> busy_r[$past(evt_i.seek_drv)])
      else $error("busy bit not set after seek");

   a_cip_clear: assert property ( // RULE18
      @(posedge sys_clk) disable iff (rst)
      (!hold && !evt_i.cmd_first && evt_i.result_last) |=> !cip_r)
      else $error("progress bit not cleared");

   a_rqm_drop: assert property ( // RULE21
      @(posedge sys_clk) disable iff (rst)
      evt_i.data_xfer |=> !rqm_r)
      else $error("request bit stayed after transfer");

   a_hold_zero: assert property ( // RULE14
      @(posedge sys_clk) disable iff (rst)
      (rd_go && !wb_we_i && wb_adr_i == OFS_MCS && hold)
      |=> wb_ack_o && wb_dat_o == 32'h0)
      else $error("status not zero while held");

   a_gate_legacy: assert property ( // RULE1
      @(posedge sys_clk) disable iff (rst)
      (!cfg_r[CFG_ALT] && !doc_r[DOC_DMA]) |=> drq_oe_n && irq_oe_n
      && dack_gated_n && !tc_gated)
      else $error("dma signals not gated");

   a_gate_alt: assert property ( // RULE2
      @(posedge sys_clk) disable iff (rst)
      cfg_r[CFG_ALT] |=> !drq_oe_n && !irq_oe_n)
      else $error("dma signals gated in alternate mode");

   a_tape_none: assert property ( // RULE8
      @(posedge sys_clk) disable iff (rst)
      ##1 !tape_drive[0] && $countones(tape_drive) <= 1)
      else $error("tape drive 0 assigned");

   a_two_motor: assert property ( // RULE3
      @(posedge sys_clk) disable iff (rst)
      (!four && xch == XCH_NONE) |=> motor_on[1:0]
      == $past(doc_r[DOC_MOT_LO +: 2]))
      else $error("motor outputs do not follow enable bits");

   a_sel_onehot: assert property ( // RULE6
      @(posedge sys_clk) disable iff (rst)
      ##1 $countones(drive_sel) <= 1)
      else $error("more than one drive selected");

   a_ready_time: assert property ( // RULE15
      @(posedge sys_clk) disable iff (rst)
      (!hold && evt_i.ready && !evt_i.data_xfer) |=> rqm_r)
      else $error("ready status missing after init");
endmodule : fdh_host_regs

// >>> testbench/fdh_host_model.sv
// host bus master model speaking classic wishbone to the register block
`timescale 1ns/1ps
module fdh_host_model
(
   input  wire logic        sys_clk,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   output logic             wb_cyc_i,
   output logic             wb_stb_i,
   output logic             wb_we_i,
   output logic [3:0]       wb_adr_i,
   output logic [3:0]       wb_sel_i,
   output logic [31:0]      wb_dat_i
);
   import fdh_pkg::*;

   initial
   begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
   end

   // request held until ack is sampled high at an edge
   task automatic xfer(input logic we, input logic [3:0] adr,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h3;
      wb_dat_i <= d;
      do
      begin
         @(posedge sys_clk);
      end
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : xfer

   // status polled before each data byte, no delay inserted
   task automatic poll(output logic [31:0] q);
      xfer(1'b0, OFS_MCS, 32'h0, q);
   endtask : poll
endmodule : fdh_host_model

// >>> testbench/test_floppy_ctrl_host_status_regs.sv
// self-checking bench for the host status registers
`timescale 1ns/1ps
module test_floppy_ctrl_host_status_regs;
   import fdh_pkg::*;
   localparam int INIT = 20;
   logic        sys_clk, rst, cyc, stb, we, ack, pwr_down;
   logic [3:0]  adr, sel, drive_sel, motor_on, tape_drive;
   logic [31:0] dat_w, dat_r;
   logic        ctrl_run, dack_g_n, tc_g, drq, drq_oe_n, irq, irq_oe_n;
   fdh_evt_t    evt;
   fdh_pins_t   pins;
   int          n_mismatch = 0;
   int          compares = 0;

   fdh_host_regs #(.INIT_CYCLES(INIT)) fdh_host_regs_i
   (
      .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .evt_i(evt), .pwr_down(pwr_down),
      .pins_i(pins), .drq_req(1'b1), .irq_req(1'b1),
      .drive_sel(drive_sel), .motor_on(motor_on), .tape_drive(tape_drive),
      .ctrl_run(ctrl_run), .dack_gated_n(dack_g_n), .tc_gated(tc_g),
      .drq_o(drq), .drq_oe_n(drq_oe_n), .irq_o(irq), .irq_oe_n(irq_oe_n)
   );

   fdh_host_model fdh_host_model_i
   (
      .sys_clk(sys_clk), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      fdh_host_model_i.xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      fdh_host_model_i.xfer(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask : rd

   task automatic ms(input logic [31:0] exp);
      logic [31:0] q;
      fdh_host_model_i.poll(q);
      check(q, exp);
   endtask : ms

   // select and motor pins, after the register-to-pin lag
   task automatic outs(input logic [31:0] e);
      repeat (3) @(posedge sys_clk);
      check(32'({drive_sel, motor_on}), e);
   endtask : outs

   // float enables and gated dma inputs
   task automatic gate(input logic [31:0] e);
      repeat (3) @(posedge sys_clk);
      check(32'({drq_oe_n, irq_oe_n, dack_g_n, tc_g}), e);
   endtask : gate

   task automatic fire(input fdh_evt_t p);
      @(posedge sys_clk);
      evt <= evt | p;
      @(posedge sys_clk);
      evt <= evt & ~p;
   endtask : fire

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial
   begin
      rst = 1'b1;
      pwr_down = 1'b0;
      evt = '0;
      pins = '{media_sense_high: 1'b1, media_sense_low: 1'b0,
               tc: 1'b1, dack_n: 1'b0};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      gate(32'hE);
      rd(OFS_DOC, 32'h0);
      ms(32'h0);
      rd(4'h1, 32'h0);
      wr(OFS_CFG, 32'h0602);
      rd(OFS_TMDT, 32'hB0);
      wr(OFS_DOC, 32'h1C);
      outs(32'h11);
      gate(32'h1);
      check(32'({drq, irq}), 32'h3);
      rd(OFS_TMDT, 32'hA0);
      wr(OFS_DOC, 32'h2D);
      outs(32'h22);
      rd(OFS_TMDT, 32'h90);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_TMDT, 32'(i));
         repeat (3) @(posedge sys_clk);
         check(32'(tape_drive), i == 0 ? 32'h0 : 32'h1 << i);
         rd(OFS_TMDT, 32'h90 | 32'(i));
      end
      wr(OFS_CFG, 32'h0600);
      wr(OFS_TMDT, 32'hFF);
      rd(OFS_TMDT, 32'h03);
      wr(OFS_DOC, 32'h25);
      gate(32'hE);
      wr(OFS_CFG, 32'h0604);
      gate(32'h1);
      wr(OFS_CFG, 32'h0603);
      wr(OFS_TMDT, 32'h08);
      wr(OFS_DOC, 32'h4E);
      outs(32'h44);
      wr(OFS_DOC, 32'h8F);
      outs(32'h88);
      wr(OFS_DOC, 32'h5C);
      outs(32'h11);
      wr(OFS_CFG, 32'h0602);
      wr(OFS_DOC, 32'h4E);
      outs(32'h11);
      wr(OFS_TMDT, 32'h04);
      wr(OFS_DOC, 32'h1C);
      outs(32'h22);
      evt.ready <= 1'b1;
      wr(OFS_DOC, 32'h18);
      ms(32'h0);
      check(32'(ctrl_run), 32'h0);
      wr(OFS_DOC, 32'h1C);
      ms(32'h0);
      repeat (INIT) @(posedge sys_clk);
      check(32'(ctrl_run), 32'h1);
      ms(32'h80);
      fire('{cmd_first: 1'b1, default: '0});
      ms(32'h90);
      fire('{result_last: 1'b1, default: '0});
      ms(32'h80);
      evt.no_result <= 1'b1;
      fire('{cmd_first: 1'b1, default: '0});
      fire('{cmd_last: 1'b1, default: '0});
      ms(32'h80);
      for (int d = 0; d < 4; d++)
      begin
         fire('{seek_done: 1'b1, seek_drv: 2'(d), default: '0});
         ms(32'h80 | 32'h1 << d);
         fire('{sense_rd: 1'b1, sense_drv: 2'(d + 1), default: '0});
         ms(32'h80 | 32'h1 << d);
         fire('{sense_rd: 1'b1, sense_drv: 2'(d), default: '0});
         ms(32'h80);
      end
      wr(OFS_MCS, 32'hFF);
      ms(32'h80);
      evt.exec_nondma <= 1'b1;
      evt.dir_read <= 1'b1;
      ms(32'hE0);
      evt.dir_read <= 1'b0;
      ms(32'hA0);
      evt.data_xfer <= 1'b1;
      @(posedge sys_clk);
      evt.data_xfer <= 1'b0;
      evt.ready <= 1'b0;
      ms(32'h20);
      evt.ready <= 1'b1;
      ms(32'hA0);
      pwr_down <= 1'b1;
      ms(32'h0);
      pwr_down <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rd(OFS_DOC, 32'h0);
      ms(32'h0);
      gate(32'hE);
      tally_and_finish();
   end
endmodule : test_floppy_ctrl_host_status_regs
